/* design/measurement_irq_mode_select.sv */
// measurement irq mode register and flag-set decoding
`timescale 1ns/100ps
`default_nettype none
module measurement_irq_mode_select
(
  // sequencer clock
  input wire logic mclk,
  // synchronous reset, active low
  input wire logic rst_n,
  // register write from the serial bus decoder
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  // registered read data back to the decoder
  output logic [7:0] regRdata,
  // sequencer revision
  input wire logic [7:0] seqRevision,
  // proximity enables from the enable register
  input wire logic prox1_irq_enable,
  input wire logic prox2_irq_enable,
  // light enables, bit 0 for flag 0 and bit 1 for flag 1
  input wire logic [1:0] light_irq_enable,
  // proximity thresholds
  input wire logic [15:0] prox1_threshold,
  input wire logic [15:0] prox2_threshold,
  // light window bounds, both inclusive
  input wire logic [15:0] light_lower_threshold,
  input wire logic [15:0] light_upper_threshold,
  // first proximity result, done pulse marks it valid
  input wire logic prox1Done,
  input wire logic [15:0] prox1Result,
  // second proximity result
  input wire logic prox2Done,
  input wire logic [15:0] prox2Result,
  // visible light result
  input wire logic visibleDone,
  input wire logic [15:0] visible_light_channel,
  // infrared light result
  input wire logic infraredDone,
  input wire logic [15:0] infrared_light_channel,
  // proximity flag-set pulses
  output logic prox1SetFlag,
  output logic prox2SetFlag,
  // light flag-set pulses
  output logic [1:0] lightSetFlag,
  // irq pin drive, high while active
  output logic irqPinActive
);
  // all module state, registered in one process
  typedef struct packed {
    // software mode register, bit 3 held at zero
    logic [7:0] modes;
    // read data for the address of the last cycle
    logic [7:0] rdata;
    // window side of the last sample, visible at 0, infrared at 1
    logic [1:0] prevIn;
    // proximity flag-set pulses, one cycle each
    logic prox1Set;
    logic prox2Set;
    // light flag-set pulses, one cycle each
    logic [1:0] lightSet;
    // irq pin drive, one cycle after light flag 0
    logic irqPin;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  // one carrier per proximity channel
  prox_event_if prox1Ch ();
  prox_event_if prox2Ch ();

  // light mode field and the revision gate
  logic [2:0] light_irq_mode;
  logic lightDecode;

  // decoded light mode selections
  logic lightEveryMode;
  logic modeExitVis;
  logic modeExitIr;
  logic modeEnterVis;
  logic modeEnterIr;

  // per light channel window state, index 0 visible, 1 infrared
  logic [1:0] chanDone;
  logic [1:0][15:0] chanResult;
  logic [1:0] chanAboveLow;
  logic [1:0] chanBelowHigh;
  logic [1:0] chanIn;
  logic [1:0] chanPrevIn;
  logic [1:0] chanLeave;
  logic [1:0] chanEnter;

  // light flag-set terms before registering
  logic everyHit;
  logic exitVisHit;
  logic exitIrHit;
  logic enterVisHit;
  logic enterIrHit;
  logic flag0Hit;
  logic flag1Hit;

  // register access decode
  logic modesSelected;
  logic modesWrite;
  logic [7:0] modesWritten;
  logic [7:0] readValue;

  ////////////////////////////////////////////////////////////////////////
  // proximity channels
  // first channel: sample, threshold and enable straight from the ports
  assign prox1Ch.done = prox1Done;
  assign prox1Ch.result = prox1Result;
  assign prox1Ch.threshold = prox1_threshold;
  assign prox1Ch.enable = prox1_irq_enable;
  // mode bits 5:4 follow the register at once, no extra delay
  assign prox1Ch.mode = state.modes[irq_mode_pkg::PROX1_MODE_LSB +: 2];

  // second channel, same wiring, mode bits 7:6
  assign prox2Ch.done = prox2Done;
  assign prox2Ch.result = prox2Result;
  assign prox2Ch.threshold = prox2_threshold;
  assign prox2Ch.enable = prox2_irq_enable;
  assign prox2Ch.mode = state.modes[irq_mode_pkg::PROX2_MODE_LSB +: 2];

  prox_irq_judge prox1Judge
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .ch(prox1Ch.judge)
  );

  // second judge; its pulse is registered again in the top state
  prox_irq_judge prox2Judge
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .ch(prox2Ch.judge)
  );

  ////////////////////////////////////////////////////////////////////////
  // light mode decode
  assign light_irq_mode = state.modes[irq_mode_pkg::LIGHT_MODE_LSB +: 3];
  // older sequencers ignore the light mode entirely
  assign lightDecode = seqRevision >= irq_mode_pkg::LIGHT_DECODE_MIN_REV;
  // all-zero field: every visible sample on flag 0
  assign lightEveryMode = light_irq_mode == irq_mode_pkg::LIGHT_EVERY_SAMPLE;
  // x01: visible leaves the window, flag 0
  assign modeExitVis = light_irq_mode[0] && !light_irq_mode[1];
  // x11: infrared leaves the window, flag 0
  assign modeExitIr = light_irq_mode[0] && light_irq_mode[1];
  // 10x: visible enters the window, flag 1
  assign modeEnterVis = light_irq_mode[2] && !light_irq_mode[1];
  // 11x: infrared enters the window, flag 1
  assign modeEnterIr = light_irq_mode[2] && light_irq_mode[1];

  ////////////////////////////////////////////////////////////////////////
  // light window per channel
  assign chanDone = {infraredDone, visibleDone};
  assign chanResult = {infrared_light_channel, visible_light_channel};
  assign chanPrevIn = state.prevIn;

  // inclusive window; both channels share the same bounds
  for (genvar i = 0; i < 2; i++)
  begin : g_window
    assign chanAboveLow[i] = chanResult[i] >= light_lower_threshold;
    assign chanBelowHigh[i] = chanResult[i] <= light_upper_threshold;
    assign chanIn[i] = chanAboveLow[i] && chanBelowHigh[i];
    // only a change of side counts, so a result that stays out is quiet
    assign chanLeave[i] = chanDone[i] && chanPrevIn[i] && !chanIn[i];
    assign chanEnter[i] = chanDone[i] && !chanPrevIn[i] && chanIn[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // light flag-set terms
  // enable 00 with the all-zero field leaves both flags quiet
  assign everyHit = lightEveryMode && chanDone[0];
  assign exitVisHit = modeExitVis && chanLeave[0];
  assign exitIrHit = modeExitIr && chanLeave[1];
  assign enterVisHit = modeEnterVis && chanEnter[0];
  assign enterIrHit = modeEnterIr && chanEnter[1];
  // each flag needs its own enable bit; the revision gate comes first
  assign flag0Hit = lightDecode && light_irq_enable[0] && (everyHit || exitVisHit || exitIrHit);
  assign flag1Hit = lightDecode && light_irq_enable[1] && (enterVisHit || enterIrHit);

  ////////////////////////////////////////////////////////////////////////
  // register access decode
  assign modesSelected = regAddr == irq_mode_pkg::MODES_OFFSET;
  assign modesWrite = regWrite && modesSelected;
  // reserved bit 3 is never stored, so it always reads zero
  assign modesWritten = regWdata & irq_mode_pkg::MODES_WRITE_MASK;
  // other addresses read zero from this block
  assign readValue = modesSelected ? state.modes : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // next register, window sides, pulses and irq pin
  always_comb
  begin
    next_state = state;

    // window side kept per channel on every sample, watched or not
    for (int i = 0; i < 2; i++)
    begin
      if (chanDone[i])
        next_state.prevIn[i] = chanIn[i];
    end

    if (modesWrite)
      next_state.modes = modesWritten;
    // read data answers this cycle's address one cycle later
    next_state.rdata = readValue;

    // pulses last one cycle; the sequencer keeps the sticky flags
    next_state.lightSet = {flag1Hit, flag0Hit};
    next_state.prox1Set = prox1Ch.setFlag;
    next_state.prox2Set = prox2Ch.setFlag;
    // pin pulses with each enabled light flag 0 set
    next_state.irqPin = light_irq_enable[0] && state.lightSet[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronous reset; mode register back to all zeros
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state <= '0;
      state.modes <= irq_mode_pkg::MODES_RESET;
    end
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  // read data
  assign regRdata = state.rdata;
  // flag-set pulses
  assign prox1SetFlag = state.prox1Set;
  assign prox2SetFlag = state.prox2Set;
  assign lightSetFlag = state.lightSet;
  // irq pin drive
  assign irqPinActive = state.irqPin;
endmodule : measurement_irq_mode_select
`default_nettype wire

/* shared/irq_mode_pkg.sv */
// constants shared by the measurement irq mode logic
`default_nettype none
package irq_mode_pkg;
  localparam logic [7:0] MODES_OFFSET = 8'h05;
  localparam logic [7:0] MODES_RESET = 8'h00;
  localparam logic [7:0] MODES_WRITE_MASK = 8'hf7;
  localparam int PROX2_MODE_LSB = 6;
  localparam int PROX1_MODE_LSB = 4;
  localparam int LIGHT_MODE_LSB = 0;
  localparam int RESULT_WIDTH = 16;
  // first sequencer revision that decodes the light mode; value is arbitrary
  localparam logic [7:0] LIGHT_DECODE_MIN_REV = 8'h01;
  localparam logic [1:0] PROX_ON_COMPLETE = 2'h0;
  localparam logic [1:0] PROX_ON_CROSS = 2'h1;
  localparam logic [1:0] PROX_RESERVED = 2'h2;
  localparam logic [1:0] PROX_ON_ABOVE = 2'h3;
  localparam logic [2:0] LIGHT_EVERY_SAMPLE = 3'h0;
endpackage : irq_mode_pkg
`default_nettype wire

/* shared/prox_event_if.sv */
// per-channel proximity sample and flag-set request between modules
`timescale 1ns/100ps
`default_nettype none
interface prox_event_if;
  logic done;
  logic [irq_mode_pkg::RESULT_WIDTH-1:0] result;
  logic [irq_mode_pkg::RESULT_WIDTH-1:0] threshold;
  logic enable;
  logic [1:0] mode;
  logic setFlag;
  modport judge (input done, result, threshold, enable, mode, output setFlag);
  modport source (output done, result, threshold, enable, mode, input setFlag);
endinterface : prox_event_if
`default_nettype wire

/* design/prox_irq_judge.sv */
// decides when one proximity channel sets its irq flag
`timescale 1ns/100ps
`default_nettype none
module prox_irq_judge
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // channel sample and mode
  prox_event_if.judge ch
);
  typedef struct packed {
    logic prevAbove;
    logic setFlag;
  } judge_state_t;

  judge_state_t state;
  judge_state_t next_state;
  logic above;

  assign ch.setFlag = state.setFlag;

  // side of threshold for the new sample
  assign above = ch.result > ch.threshold;

  // one-cycle set pulse for a completed sample when enabled and the mode selects it
  always_comb
  begin
    next_state = state;
    next_state.setFlag = 1'b0;
    if (ch.done)
    begin
      next_state.prevAbove = above;
      if (ch.enable)
      begin
        unique case (ch.mode)
          irq_mode_pkg::PROX_ON_COMPLETE: next_state.setFlag = 1'b1;
          irq_mode_pkg::PROX_ON_CROSS: next_state.setFlag = above != state.prevAbove;
          irq_mode_pkg::PROX_ON_ABOVE: next_state.setFlag = above;
          irq_mode_pkg::PROX_RESERVED: next_state.setFlag = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state <= '0;
    else
      state <= next_state;
  end
endmodule : prox_irq_judge
`default_nettype wire

/* sim/irq_mode_properties.sv */
// concurrent checks on the irq mode select ports
`timescale 1ns/100ps
`default_nettype none
module irq_mode_properties
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register access
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // enables and samples
  input wire logic [7:0] seqRevision,
  input wire logic prox1_irq_enable,
  input wire logic [1:0] light_irq_enable,
  input wire logic prox1Done,
  input wire logic visibleDone,
  // flag pulses
  input wire logic prox1SetFlag,
  input wire logic prox2SetFlag,
  input wire logic [1:0] lightSetFlag,
  input wire logic irqPinActive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [7:0] modes;
  // shadow of the mode register; bit 3 never stored
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      modes <= 8'h00;
    else if (regWrite && regAddr == 8'h05)
      modes <= regWdata & 8'hf7;
  end
  a_read_back: assert property (regAddr == 8'h05 |=> regRdata == $past(modes))
    else $error("mode register read back wrong");
  a_bit3_zero: assert property (regRdata[3] == 1'b0)
    else $error("reserved bit reads one");
  a_prox1_done: assert property (prox1Done && prox1_irq_enable && modes[5:4] == 2'h0 |-> ##2 prox1SetFlag)
    else $error("prox1 completion flag missing");
  a_prox1_gate: assert property (prox1SetFlag |-> $past(prox1Done, 2) && $past(prox1_irq_enable, 2))
    else $error("prox1 flag without enabled sample");
  a_prox2_reserved: assert property (prox2SetFlag |-> $past(modes[7:6], 2) != 2'h2)
    else $error("prox2 flag in reserved mode");
  a_light_quiet: assert property (lightSetFlag != 2'h0 |-> $past(light_irq_enable) != 2'h0)
    else $error("light flag while light disabled");
  a_light_every: assert property (visibleDone && light_irq_enable == 2'h1 && modes[2:0] == 3'h0
    && seqRevision >= 8'h01 |=> lightSetFlag[0])
    else $error("light flag 0 missing after sample");
  a_pin_follow: assert property (lightSetFlag[0] && light_irq_enable[0] |=> irqPinActive)
    else $error("irq pin did not follow light flag 0");
  // main scenarios reached
  c_prox1: cover property (prox1SetFlag);
  c_light1: cover property (lightSetFlag[1]);
  c_pin: cover property (irqPinActive);
endmodule : irq_mode_properties
bind measurement_irq_mode_select irq_mode_properties chk_u (.*);
`default_nettype wire

/* sim/irq_flag_host.sv */
// host-side sticky flags collecting the set pulses
`timescale 1ns/100ps
`default_nettype none
module irq_flag_host
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pulses in, clear from the host
  input wire logic [4:0] setPulse,
  input wire logic clear,
  // flags as the host reads them
  output logic [4:0] flags
);
  // sticky, so a one-cycle pulse is never missed; a pulse beside a clear still lands
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      flags <= 5'h00;
    else
      flags <= (clear ? 5'h00 : flags) | setPulse;
  end
endmodule : irq_flag_host
`default_nettype wire

/* sim/measurement_irq_mode_select_tb.sv */
// self-checking bench for the irq mode select
`timescale 1ns/100ps
`default_nettype none
module measurement_irq_mode_select_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic regWrite = 1'b0, clear = 1'b0, en1 = 1'b1, en2 = 1'b1, p1, p2, pin;
  logic [7:0] rev = 8'h01;
  logic [1:0] lightEn = 2'h0, lt;
  logic [3:0] done = 4'h0;
  logic [15:0] res [4] = '{default: 16'h0000};
  logic [4:0] flags;
  logic [2:0] proxExp [4] = '{3'b111, 3'b101, 3'b000, 3'b110};
  int num_errors = 0, num_checks = 0, cyc = 0;
  measurement_irq_mode_select dut_u (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .seqRevision(rev), .prox1_irq_enable(en1),
    .prox2_irq_enable(en2), .light_irq_enable(lightEn), .prox1_threshold(16'h0064), .prox2_threshold(16'h0064),
    .light_lower_threshold(16'h0064), .light_upper_threshold(16'h00c8), .prox1Done(done[0]),
    .prox1Result(res[0]), .prox2Done(done[1]), .prox2Result(res[1]), .visibleDone(done[2]),
    .visible_light_channel(res[2]), .infraredDone(done[3]), .infrared_light_channel(res[3]),
    .prox1SetFlag(p1), .prox2SetFlag(p2), .lightSetFlag(lt), .irqPinActive(pin));
  irq_flag_host host_u (.mclk(mclk), .rst_n(rst_n), .setPulse({pin, lt, p2, p1}), .clear(clear), .flags(flags));
  always #4 mclk = ~mclk;
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      complete_run();
    end
  end
  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
  begin
    num_checks++;
    if (got !== exp)
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    if (got !== exp)
      num_errors++;
  end
  endtask : compare
  task automatic compare_flags(input logic [4:0] got, input logic [4:0] exp);
  begin
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %0t flags %b expected %b", $time, got, exp);
      num_errors++;
    end
  end
  endtask : compare_flags
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(negedge mclk);
    {regAddr, regWdata, regWrite} = {a, d, 1'b1};
    @(negedge mclk);
    regWrite = 1'b0;
  end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
  begin
    @(negedge mclk);
    regAddr = a;
    @(negedge mclk);
    compare(regRdata, exp);
  end
  endtask : rd
  // one sample on a channel, then flags read and cleared by the host
  task automatic smp(input int ch, input logic [15:0] v, input logic [4:0] e);
  begin
    @(negedge mclk);
    res[ch] = v;
    done[ch] = 1'b1;
    @(negedge mclk);
    done[ch] = 1'b0;
    repeat (3) @(negedge mclk);
    compare_flags(flags, e);
    clear = 1'b1;
    @(negedge mclk);
    clear = 1'b0;
  end
  endtask : smp
  task automatic complete_run();
  begin
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask : complete_run
  initial
  begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'hf7);
    // every proximity mode, samples above, above, below
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h05, {m[1:0], m[1:0], 4'h0});
      for (int ch = 0; ch < 2; ch++)
        for (int k = 0; k < 3; k++)
          smp(ch, k == 2 ? 16'h0032 : 16'h0096, 5'(proxExp[m][2-k]) << ch);
    end
    wr(8'h05, 8'h00);
    {en1, en2} = 2'h0;
    smp(0, 16'h0096, 5'h00);
    smp(1, 16'h0096, 5'h00);
    smp(2, 16'h0096, 5'h00);
    lightEn = 2'h1;
    smp(2, 16'h0096, 5'h14);
    lightEn = 2'h3;
    wr(8'h05, 8'h05);
    smp(2, 16'h00fa, 5'h14);
    smp(2, 16'h0096, 5'h08);
    wr(8'h05, 8'h07);
    smp(3, 16'h0096, 5'h08);
    smp(3, 16'h00fa, 5'h14);
    smp(2, 16'h0032, 5'h00);
    // an infrared entry that would flag, but on an older sequencer
    rev = 8'h00;
    smp(3, 16'h0096, 5'h00);
    // reset in mid-run brings the mode register back to zero
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    rd(8'h05, 8'h00);
    complete_run();
  end
endmodule : measurement_irq_mode_select_tb
`default_nettype wire
